// *** tb/thermal_alert_monitor_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alert_cfg.svh"

module thermal_alert_monitor_bench
  import thermal_alert_pkg::*;
;
  logic        i_clock;
  logic        i_rst;
  logic        pin_n;
  logic        lvl;
  logic        glitch;
  logic        i_sel;
  logic        i_write;
  logic [7:0]  i_addr;
  logic [3:0]  i_be;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  logic        o_irq;
  int          n_fail;
  int          checked;

  thermal_alert_monitor dut (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_throttle_in_n (pin_n),
    .i_sel           (i_sel),
    .i_write         (i_write),
    .i_addr          (i_addr),
    .i_be            (i_be),
    .i_wdata         (i_wdata),
    .o_rdata         (o_rdata),
    .o_irq           (o_irq)
  );

  throttle_driver cpu (
    .i_clock  (i_clock),
    .i_level  (lvl),
    .i_glitch (glitch),
    .o_pin_n  (pin_n)
  );

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    i_sel   <= 1'b1;
    i_write <= 1'b1;
    i_addr  <= a;
    i_be    <= be;
    i_wdata <= d;
    @(posedge i_clock);
    i_sel   <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
    i_sel   <= 1'b1;
    i_write <= 1'b0;
    i_addr  <= a;
    i_be    <= be;
    @(posedge i_clock);
    i_sel   <= 1'b0;
    @(posedge i_clock);
    #1;
    chk(o_rdata, exp);
    @(posedge i_clock);
  endtask : rd

  // Waits are in clock cycles; counts follow the tick spacing of the core
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask : idle

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Whole sequence is about 26k cycles; a hang is cut at 50k
  initial begin
    repeat (50000) @(posedge i_clock);
    n_fail++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    n_fail = 0;
    checked = 0;
    i_rst = 1'b1;
    lvl = 1'b1;
    glitch = 1'b0;
    i_sel = 1'b0;
    i_write = 1'b0;
    i_addr = 8'h00;
    i_be = 4'h0;
    i_wdata = 32'h0000_0000;
    idle(10);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rd(8'h0C, 4'hF, 32'h0000_0000);
    rd(8'h14, 4'hF, 32'h0000_0000);
    rd(8'h10, 4'hF, 32'h0000_0000);
    rd(8'h20, 4'hF, 32'h0000_0000);
    wr(8'h14, 4'hF, 32'h0000_0003);
    rd(8'h14, 4'hF, 32'h0000_0003);
    $display("Test reset done");
    // Disabled: pin low across a tick changes nothing
    lvl <= 1'b0;
    idle(2900);
    rd(8'h10, 4'hF, 32'h0000_0000);
    rd(8'h0C, 4'hF, 32'h0000_0000);
    $display("Test idle done");
    // Enabled with the assertion interrupt on
    wr(8'h0C, 4'h1, 32'h0000_0005);
    idle(3 * 2777 + 40);
    rd(8'h10, 4'hF, 32'h0000_0003);
    rd(8'h10, 4'h1, 32'h0000_0003);
    rd(8'h10, 4'h2, 32'h0000_0000);
    rd(8'h0C, 4'hF, 32'h0000_0405);
    chk({31'h0, o_irq}, 32'h0000_0001);
    wr(8'h0C, 4'h3, 32'h0000_0401);
    rd(8'h0C, 4'hF, 32'h0000_0401);
    chk({31'h0, o_irq}, 32'h0000_0000);
    lvl <= 1'b1;
    idle(40);
    rd(8'h10, 4'hF, 32'h0000_0000);
    rd(8'h0C, 4'hF, 32'h0000_0403);
    wr(8'h0C, 4'h3, 32'h0000_0405);
    rd(8'h0C, 4'hF, 32'h0000_0007);
    chk({31'h0, o_irq}, 32'h0000_0000);
    $display("Test limit done");
    // Soft clear, then a zero limit never raises the flag
    wr(8'h0C, 4'h1, 32'h0000_0010);
    rd(8'h0C, 4'hF, 32'h0000_0002);
    rd(8'h14, 4'hF, 32'h0000_0000);
    lvl <= 1'b0;
    wr(8'h0C, 4'h1, 32'h0000_0005);
    idle(2777 + 40);
    rd(8'h10, 4'hF, 32'h0000_0001);
    rd(8'h0C, 4'hF, 32'h0000_0005);
    $display("Test zero limit done");
    // Filter swallows the glitch train
    lvl <= 1'b1;
    wr(8'h0C, 4'h1, 32'h0000_0025);
    idle(40);
    glitch <= 1'b1;
    idle(2900);
    rd(8'h10, 4'hF, 32'h0000_0000);
    // Eight reads three cycles apart land on every phase of the train
    repeat (8) rd(8'h0C, 4'hF, 32'h0000_0027);
    glitch <= 1'b0;
    $display("Test filter done");
    // Period countdown of two units
    wr(8'h0C, 4'h1, 32'h0000_0010);
    wr(8'h08, 4'hF, 32'h0000_0002);
    wr(8'h0C, 4'h1, 32'h0000_0009);
    idle(2 * 2775 + 60);
    rd(8'h0C, 4'hF, 32'h0000_000B);
    idle(2775);
    rd(8'h0C, 4'hF, 32'h0000_080B);
    chk({31'h0, o_irq}, 32'h0000_0001);
    rd(8'h04, 4'hF, 32'h0000_0000);
    wr(8'h0C, 4'h3, 32'h0000_0001);
    chk({31'h0, o_irq}, 32'h0000_0000);
    rd(8'h0C, 4'hF, 32'h0000_0803);
    wr(8'h0C, 4'h3, 32'h0000_0801);
    rd(8'h0C, 4'hF, 32'h0000_0003);
    $display("Test period done");
    end_sim();
  end
endmodule : thermal_alert_monitor_bench

`default_nettype wire

// *** tb/throttle_driver.sv ***
`timescale 1ns/1ps
`default_nettype none

module throttle_driver (
  // Control
  input  wire logic i_clock,
  input  wire logic i_level,
  input  wire logic i_glitch,
  // Pin
  output logic      o_pin_n
);
  logic [2:0] ph_q = 3'h0;

  always_ff @(posedge i_clock) begin
    ph_q <= ph_q + 3'h1;
  end

  // Train of 20 ns low and 12 ns high pulses, none stable for the filter span
  always_comb begin
    o_pin_n = i_glitch ? (ph_q > 3'h4) : i_level;
  end
endmodule : throttle_driver

`default_nettype wire

// *** verilog/monitor_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface monitor_if;
  logic run;
  logic raw_n;
  logic filt_en;
  logic clean_n;
  logic slow_tick;
  logic unit_tick;

  modport filt (input run, input raw_n, input filt_en, output clean_n);
  modport tick (input run, output slow_tick, output unit_tick);
  modport core (output run, output raw_n, output filt_en,
                input clean_n, input slow_tick, input unit_tick);
endinterface : monitor_if

`default_nettype wire

// *** verilog/thermal_alert_cfg.svh ***
`ifndef THERMAL_ALERT_CFG_SVH
`define THERMAL_ALERT_CFG_SVH

// Register offsets (byte addresses)
`define TA_OFS_CUM      8'h00
`define TA_OFS_DUTY     8'h04
`define TA_OFS_PERIOD   8'h08
`define TA_OFS_STATUS   8'h0C
`define TA_OFS_ASSERT   8'h10
`define TA_OFS_LIMIT    8'h14

// Status/control field positions
`define TA_BIT_ON       0
`define TA_BIT_LEVEL    1
`define TA_BIT_AE       2
`define TA_BIT_PE       3
`define TA_BIT_CLEAR    4
`define TA_BIT_FILT     5
`define TA_BIT_FLAG_A   10
`define TA_BIT_FLAG_P   11

// Reset values and saturation limits
`define TA_RST_LIMIT    16'h0000
`define TA_RST_PERIOD   24'h00_0000
`define TA_CNT_MAX      16'hFFFF
`define TA_CUM_MAX      24'hFF_FFFF

// Timing
`define TA_CLK_MHZ      250
`define TA_CLK_HZ       250000000
`define TA_SLOW_HZ      90000
`define TA_UNIT_NS      11100
`define TA_FILT_NS      31
`define TA_SLOW_CYC     (`TA_CLK_HZ / `TA_SLOW_HZ)
`define TA_UNIT_CYC     ((`TA_UNIT_NS * `TA_CLK_MHZ) / 1000)
`define TA_FILT_CYC     ((`TA_FILT_NS * `TA_CLK_MHZ + 999) / 1000)

`endif

// *** verilog/thermal_alert_monitor.sv ***
// Summary of operation
// - Disabled monitor freezes status bits and counters
// - Idle state stops prescalers and filter, keeps registers
// - Level bit mirrors pin, only while enabled
// - Assertion interrupt passes only when enabled
// - Period interrupt passes only when enabled
// - Soft clear write restores core register defaults; level reloads from pin
// - Count at or above limit sets flag
// - Assertion flag clears only once limit unmet
// - Period flag set on countdown end, write-one-clear
// - Optional filter drops glitches below ~31 ns
// - Byte0 read latches upper bytes for narrow reads
// - 16-bit 90 kHz count while pin low
// - Assertion counter saturates at FFFFh
// - Limit hit with enable raises interrupt
// - Zero limit disables comparison
// - Period countdown copies cumulative count, reloads
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alert_cfg.svh"

module thermal_alert_monitor
  import thermal_alert_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Throttle pin
  input  wire logic        i_throttle_in_n,
  // Register port
  input  wire logic        i_sel,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_addr,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_rdata,
  // Interrupt
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for writable registers
  function automatic logic [23:0] merge24(input logic [23:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [23:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge24

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  monitor_if mon ();

  core_state_s q;
  core_state_s d;

  logic wr;
  logic rd;
  logic hit;
  logic wr_stat;
  logic soft_clear;
  logic wr_period;

  assign mon.run     = q.on;
  assign mon.raw_n   = i_throttle_in_n;
  assign mon.filt_en = q.filt;

  throttle_filter u_filter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (mon)
  );

  tick_gen u_tick (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign wr         = i_sel & i_write;
  assign rd         = i_sel & ~i_write;
  assign wr_stat    = wr && (i_addr == `TA_OFS_STATUS);
  assign wr_period  = wr && (i_addr == `TA_OFS_PERIOD);
  assign soft_clear = wr_stat && i_be[0] && i_wdata[`TA_BIT_CLEAR];
  assign hit        = (q.limit != `TA_RST_LIMIT) && (q.assert_cnt >= q.limit);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;

    // Register reads; data appears one cycle after the request
    if (rd) begin
      case (i_addr)
        `TA_OFS_CUM:    d.rdata = {8'h00, q.cum};
        `TA_OFS_DUTY:   d.rdata = {8'h00, q.duty};
        `TA_OFS_PERIOD: d.rdata = {8'h00, q.period};
        `TA_OFS_STATUS: begin
          d.rdata                 = 32'h0000_0000;
          d.rdata[`TA_BIT_ON]     = q.on;
          d.rdata[`TA_BIT_LEVEL]  = q.level;
          d.rdata[`TA_BIT_AE]     = q.ae;
          d.rdata[`TA_BIT_PE]     = q.pe;
          d.rdata[`TA_BIT_FILT]   = q.filt;
          d.rdata[`TA_BIT_FLAG_A] = q.flag_a;
          d.rdata[`TA_BIT_FLAG_P] = q.flag_p;
        end
        `TA_OFS_ASSERT: begin
          // Narrow reads of upper bytes see the copy taken at the byte 0 read
          if (i_be == 4'hF || i_be[0]) begin
            d.rdata = {16'h0000, q.assert_cnt};
          end else begin
            d.rdata = {16'h0000, q.hold, 8'h00};
          end
          if (i_be[0]) begin
            d.hold = q.assert_cnt[15:8];
          end
        end
        `TA_OFS_LIMIT:  d.rdata = {16'h0000, q.limit};
        default:        d.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; flag clears come first so a same-cycle set wins
    if (wr_stat) begin
      if (i_be[0]) begin
        d.on   = i_wdata[`TA_BIT_ON];
        d.ae   = i_wdata[`TA_BIT_AE];
        d.pe   = i_wdata[`TA_BIT_PE];
        d.filt = i_wdata[`TA_BIT_FILT];
      end
      if (i_be[1] && i_wdata[`TA_BIT_FLAG_A] && !hit) begin
        d.flag_a = 1'b0;
      end
      if (i_be[1] && i_wdata[`TA_BIT_FLAG_P]) begin
        d.flag_p = 1'b0;
      end
    end
    if (wr && i_addr == `TA_OFS_LIMIT) begin
      d.limit = 16'(merge24({8'h00, q.limit}, i_wdata, i_be));
    end
    if (wr_period) begin
      d.period = merge24(q.period, i_wdata, i_be);
    end

    // Hardware updates happen only while monitoring
    if (q.on) begin
      d.level = mon.clean_n;
      // Cleared at once, not at the next slow tick, so a released pin never reads stale
      if (mon.clean_n) begin
        d.assert_cnt = 16'h0000;
      end else if (mon.slow_tick) begin
        if (q.assert_cnt != `TA_CNT_MAX) begin
          d.assert_cnt = q.assert_cnt + 16'h0001;
        end
        if (q.cum != `TA_CUM_MAX) begin
          d.cum = q.cum + 24'h00_0001;
        end
      end
      if (hit) begin
        d.flag_a = 1'b1;
      end
      if (mon.unit_tick && q.period != `TA_RST_PERIOD) begin
        if (q.down == 24'h00_0001) begin
          d.duty   = q.cum;
          d.flag_p = 1'b1;
          d.down   = q.period;
        end else if (q.down == 24'h00_0000) begin
          d.down = q.period;
        end else begin
          d.down = q.down - 24'h00_0001;
        end
      end
    end

    // A new period restarts the measurement
    if (wr_period) begin
      d.cum  = 24'h00_0000;
      d.down = 24'h00_0000;
    end

    // Soft clear overrides everything but the read data, which keeps its value; level reloads from the pin
    if (soft_clear) begin
      d       = '0;
      d.level = mon.clean_n;
      d.rdata = q.rdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_rdata = q.rdata;
  assign o_irq   = (q.flag_a & q.ae) | (q.flag_p & q.pe);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_IDLE_FROZEN: assert property (
    !q.on && !i_sel |=> $stable(q.assert_cnt) && $stable(q.cum) && $stable(q.level)
                        && $stable(q.flag_a) && $stable(q.flag_p) && $stable(q.down))
    else $error("Idle monitor changed a counter or status bit");

  AST_LEVEL_TRACK: assert property (
    q.on && !i_sel |=> q.level == $past(mon.clean_n))
    else $error("Level bit does not follow the pin");

  AST_IRQ_ASSERT_GATE: assert property (
    q.flag_a && q.ae |-> o_irq)
    else $error("Assertion interrupt not raised");

  AST_IRQ_BLOCKED: assert property (
    !(q.flag_a && q.ae) && !(q.flag_p && q.pe) |-> !o_irq)
    else $error("Interrupt raised with no enabled flag");

  AST_IRQ_PERIOD: assert property (
    q.flag_p && q.pe |-> o_irq)
    else $error("Period interrupt not raised");

  AST_SOFT_CLEAR: assert property (
    soft_clear |=> !q.on && !q.flag_a && !q.flag_p && q.limit == 16'h0000
                   && q.period == 24'h00_0000 && q.assert_cnt == 16'h0000)
    else $error("Soft clear left a register changed");

  AST_LIMIT_SET: assert property (
    q.on && hit && !i_sel |=> q.flag_a)
    else $error("Limit hit did not set the flag");

  AST_FLAG_KEEP: assert property (
    q.flag_a && hit && !soft_clear |=> q.flag_a)
    else $error("Assertion flag cleared while limit still met");

  AST_PERIOD_END: assert property (
    q.on && mon.unit_tick && q.period != 24'h00_0000 && q.down == 24'h00_0001 && !i_sel
      |=> q.flag_p && q.duty == $past(q.cum) && q.down == $past(q.period))
    else $error("Countdown end not handled");

  AST_COUNT_CLEAR: assert property (
    q.on && mon.clean_n && !i_sel |=> q.assert_cnt == 16'h0000)
    else $error("Counter not held at zero while pin high");

  AST_SATURATE: assert property (
    q.on && q.assert_cnt == 16'hFFFF && !mon.clean_n && !i_sel |=> q.assert_cnt == 16'hFFFF)
    else $error("Counter rolled over");

  AST_LIMIT_ZERO: assert property (
    q.limit == 16'h0000 && !q.flag_a |=> !q.flag_a)
    else $error("Zero limit set the flag");

  AST_HOLD_LATCH: assert property (
    rd && i_addr == `TA_OFS_ASSERT && i_be[0] |=> q.hold == $past(q.assert_cnt[15:8]))
    else $error("Byte 0 read did not latch the upper byte");

  AST_LIVE_READ: assert property (
    rd && i_addr == `TA_OFS_ASSERT && i_be == 4'hF |=> o_rdata == {16'h0000, $past(q.assert_cnt)})
    else $error("Full-width read did not return the live count");

  AST_HOLD_READ: assert property (
    rd && i_addr == `TA_OFS_ASSERT && !i_be[0] |=> o_rdata[15:8] == $past(q.hold))
    else $error("Narrow upper read did not return the held copy");

  AST_LIMIT_CLEAR: assert property (
    wr_stat && i_be[1] && i_wdata[`TA_BIT_FLAG_A] && !hit |=> !q.flag_a)
    else $error("Assertion flag not cleared once limit unmet");

  AST_FLAG_P_CLEAR: assert property (
    wr_stat && i_be[1] && i_wdata[`TA_BIT_FLAG_P] && !mon.unit_tick |=> !q.flag_p)
    else $error("Period flag not cleared by a one");

  AST_LEVEL_RESET: assert property (
    soft_clear |=> q.level == $past(mon.clean_n))
    else $error("Soft clear did not reload the level bit");

  AST_PERIOD_OFF: assert property (
    q.period == 24'h00_0000 && !i_sel |=> $stable(q.down) && $stable(q.duty) && $stable(q.flag_p))
    else $error("Zero period still ran the measurement");

  COV_SOFT_CLEAR: cover property (soft_clear);
  COV_LIMIT_HIT:  cover property (q.on && hit ##1 o_irq);
  COV_PERIOD_END: cover property ($rose(q.flag_p));
  COV_SATURATE:   cover property (q.assert_cnt == 16'hFFFF);
  COV_HELD_READ:  cover property (rd && i_addr == `TA_OFS_ASSERT && !i_be[0]);

endmodule : thermal_alert_monitor

`default_nettype wire

// *** verilog/thermal_alert_pkg.sv ***
`default_nettype none

package thermal_alert_pkg;

  typedef struct packed {
    logic [3:0] stable_cnt;
    logic       clean_n;
  } filt_state_s;

  typedef struct packed {
    logic [11:0] slow_cnt;
    logic [11:0] unit_cnt;
    logic        slow_tick;
    logic        unit_tick;
  } tick_state_s;

  typedef struct packed {
    logic        on;
    logic        ae;
    logic        pe;
    logic        filt;
    logic        flag_a;
    logic        flag_p;
    logic        level;
    logic [15:0] assert_cnt;
    logic [15:0] limit;
    logic [23:0] cum;
    logic [23:0] duty;
    logic [23:0] period;
    logic [23:0] down;
    logic [7:0]  hold;
    logic [31:0] rdata;
  } core_state_s;

endpackage : thermal_alert_pkg

`default_nettype wire

// *** verilog/throttle_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alert_cfg.svh"

module throttle_filter
  import thermal_alert_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  // Monitor carrier
  monitor_if.filt     bus
);

  filt_state_s q;
  filt_state_s d;

  always_comb begin
    d = q;
    // Frozen while idle, which stands in for the gated clock
    if (bus.run) begin
      if (bus.raw_n == q.clean_n) begin
        d.stable_cnt = 4'h0;
      end else if (q.stable_cnt == 4'(`TA_FILT_CYC - 1)) begin
        d.clean_n    = bus.raw_n;
        d.stable_cnt = 4'h0;
      end else begin
        d.stable_cnt = q.stable_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '{stable_cnt: 4'h0, clean_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  // Bypass is combinational so the unfiltered path adds no delay
  assign bus.clean_n = bus.filt_en ? q.clean_n : bus.raw_n;

  AST_FILT_BYPASS: assert property (@(posedge i_clock) disable iff (i_rst)
    !bus.filt_en |-> bus.clean_n == bus.raw_n)
    else $error("Unfiltered path does not follow the pin");

  AST_FILT_GLITCH: assert property (@(posedge i_clock) disable iff (i_rst)
    bus.filt_en && $past(bus.filt_en) && $changed(q.clean_n)
      |-> $past(q.stable_cnt) == 4'(`TA_FILT_CYC - 1))
    else $error("Filtered level changed before the input was stable");

endmodule : throttle_filter

`default_nettype wire

// *** verilog/tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alert_cfg.svh"

module tick_gen
  import thermal_alert_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  // Monitor carrier
  monitor_if.tick     bus
);

  tick_state_s q;
  tick_state_s d;

  always_comb begin
    d           = q;
    d.slow_tick = 1'b0;
    d.unit_tick = 1'b0;
    // Prescalers stop while idle instead of gating the clock itself
    if (bus.run) begin
      if (q.slow_cnt == 12'(`TA_SLOW_CYC - 1)) begin
        d.slow_cnt  = 12'h000;
        d.slow_tick = 1'b1;
      end else begin
        d.slow_cnt = q.slow_cnt + 12'h001;
      end
      if (q.unit_cnt == 12'(`TA_UNIT_CYC - 1)) begin
        d.unit_cnt  = 12'h000;
        d.unit_tick = 1'b1;
      end else begin
        d.unit_cnt = q.unit_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.slow_tick = q.slow_tick;
  assign bus.unit_tick = q.unit_tick;

  AST_TICK_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
    q.slow_tick |=> !q.slow_tick [*8])
    else $error("Slow tick is not a lone pulse");

endmodule : tick_gen

`default_nettype wire
